// file: tb/bus_port_pair_props.sv
// concurrent checks on the bus port pair ports
`timescale 1ns/10ps
module bus_port_pair_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        ext_valid,
  input wire logic        ext_ready,
  input wire logic        ext_ack,
  input wire logic        bus_addr_latch,
  input wire logic        bus_read_strobe,
  input wire logic        bus_write_strobe,
  input wire logic [15:0] bus_port_oe,
  input wire logic [15:0] bus_port_pullup,
  input wire logic [15:0] second_port_oe
);
  // --------------------
  // port relations
  // --------------------
  // reset is synchronous, so its own edges are skipped
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_pullup_held: assert property (
    $fell(rst) |-> bus_port_pullup == 16'hFFFF && bus_port_oe == 16'h0000)
    else $error("pull-ups or drivers wrong at reset release");
  chk_pullup_off: assert property (
    !$past(rst) |-> bus_port_pullup == 16'h0000)
    else $error("pull-ups still on after reset");
  chk_take_ack: assert property (
    ext_valid && ext_ready |-> ##[2:5] ext_ack)
    else $error("external access not answered in time");
  chk_busy_ready: assert property (
    ext_valid && ext_ready |=> !ext_ready [*2])
    else $error("new access offered while busy");
  chk_addr_then: assert property (
    bus_addr_latch |-> bus_port_oe == 16'hFFFF ##1 (bus_read_strobe || bus_write_strobe))
    else $error("address phase not driven or not followed by data");
  chk_read_float: assert property (
    bus_read_strobe |-> bus_port_oe[7:0] == 8'h00)
    else $error("port driven while reading");
  chk_write_drive: assert property (
    bus_write_strobe |-> bus_port_oe[7:0] == 8'hFF)
    else $error("write data not driven");
  chk_ack_single: assert property (
    ext_ack |-> !ext_ready ##1 !ext_ack)
    else $error("ack longer than one cycle");
  chk_wait_one: assert property (
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("register access wait not one cycle");
  chk_dir_write: assert property (
    $changed(second_port_oe) |-> $past(avs_write) && !$past(avs_waitrequest))
    else $error("second port drivers changed without a write");
endmodule

bind bus_port_pair bus_port_pair_props bus_port_pair_props_i (.clk, .rst, .avs_read,
  .avs_write, .avs_waitrequest, .ext_valid, .ext_ready, .ext_ack, .bus_addr_latch,
  .bus_read_strobe, .bus_write_strobe, .bus_port_oe, .bus_port_pullup, .second_port_oe);

// file: tb/bus_port_pair_test.sv
// self-checking bench for the bus port pair
`timescale 1ns/10ps
module bus_port_pair_test;
  import bus_port_pkg::*;
  logic            clk, rst, avs_read, avs_write, avs_waitrequest, ext_valid;
  logic            ext_ready, ext_ack, byte_mode, bus_addr_latch;
  logic            bus_read_strobe, bus_write_strobe;
  logic [17:0]     avs_address;
  logic [31:0]     avs_writedata, avs_readdata;
  ext_req_t        ext_req;
  logic [15:0]     ext_rdata, bus_port_in, bus_port_out, bus_port_oe, bus_port_pullup;
  logic [15:0]     second_port_out, second_port_oe, strap, rd_word, seen_a, seen_w, a, d;
  logic [15:0]     idx2 [4];
  logic [3:0]      avs_byteenable, be;
  logic [7:0]      r, v, sp [4];
  int              errors, samples_checked, seed, n_lat, n_rd, lat0, rd0, m, k;

  bus_port_pair bus_port_pair_i (.clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .ext_valid,
    .ext_req, .ext_ready, .ext_ack, .ext_rdata, .bus_addr_latch, .bus_read_strobe,
    .bus_write_strobe, .bus_port_in, .bus_port_out, .bus_port_oe, .bus_port_pullup,
    .second_port_in(16'h0000), .second_port_out, .second_port_oe);
  ext_mem_model ext_mem_model_i (.clk, .byte_mode, .strap, .rd_word, .pin_out(bus_port_out),
    .pin_oe(bus_port_oe), .pin_pullup(bus_port_pullup), .rd_strobe(bus_read_strobe),
    .pin_in(bus_port_in));

  // --------------------
  // helpers
  // --------------------
  task automatic chk(input string n, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // register access held until waitrequest is seen low
  task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, wd};
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  // one word access from the bus controller side
  task automatic ext(input logic w, input logic [15:0] ad, wd);
    ext_req <= '{w, 1'b1, ad, wd};
    ext_valid <= 1'b1;
    do @(posedge clk); while (ext_ready !== 1'b1);
    ext_valid <= 1'b0;
    do @(posedge clk); while (ext_ack !== 1'b1);
  endtask
  task automatic boot_check(input logic [7:0] hi, lo);
    repeat (2) @(posedge clk);
    acc(0, IDX_STARTUP_READBACK, 8'h00, r);
    chk("readback", {8'h00, hi}, {8'h00, r});
    acc(0, IDX_BUS_CONFIG_ZERO, 8'h00, r);
    chk("config", {8'h00, lo}, {8'h00, r});
    for (int j = 0; j < 4; j++) begin
      acc(0, idx2[j], 8'h00, r);
      chk("second_reset", 16'h0000, {8'h00, r});
    end
  endtask

  // watch the pins during bus phases
  always @(posedge clk) begin
    if (bus_addr_latch) seen_a <= bus_port_out;
    if (bus_write_strobe) seen_w <= bus_port_out;
    n_lat <= n_lat + int'(bus_addr_latch);
    n_rd  <= n_rd + int'(bus_read_strobe);
  end
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (8000) @(posedge clk);
    errors++;
    report_and_stop;
  end

  // --------------------
  // scenarios
  // --------------------
  initial begin
    seed = 22541;
    {rst, avs_read, avs_write, ext_valid, byte_mode} = 5'b10000;
    {avs_address, avs_writedata, ext_req, rd_word} = '0;
    avs_byteenable = 4'hF;
    be = 4'hF;
    strap = 16'hA5FF;
    idx2 = '{IDX_SECOND_LOW_DATA, IDX_SECOND_HIGH_DATA, IDX_SECOND_LOW_DIR, IDX_SECOND_HIGH_DIR};
    sp = '{default: 8'h00};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    boot_check(8'hA5, 8'hFF);
    // every bus mode: m[0] multiplexed, m[1] 16-bit
    for (m = 0; m < 4; m++) begin
      acc(1, IDX_BUS_CONFIG_ZERO, 8'h04 | 8'(m), r);
      byte_mode <= !m[1];
      rd_word <= 16'($random(seed));
      a = 16'($random(seed)) & 16'hFFFE;
      d = 16'($random(seed));
      {lat0, rd0} = {n_lat, n_rd};
      ext(0, a, 16'h0000);
      chk("rdata", rd_word, ext_rdata);
      chk("read_cycles", m[1] ? 16'h1 : 16'h2, 16'(n_rd - rd0));
      chk("latches", m[0] ? (m[1] ? 16'h1 : 16'h2) : 16'h0, 16'(n_lat - lat0));
      if (m[0]) chk("address", m[1] ? a : a | 16'h0001, seen_a);
      ext(1, a, d);
      chk("wdata", m[1] ? d : {8'h00, d[15:8]}, m[1] ? seen_w : {8'h00, seen_w[7:0]});
    end
    // demux8 frees the high half; bus off hands pins back to the direction registers
    acc(1, IDX_BUS_CONFIG_ZERO, 8'h04, r);
    v = 8'($random(seed));
    acc(1, IDX_BUS_PORT_HIGH_DIR, v, r);
    chk("high_half_oe", {8'h00, v}, {8'h00, bus_port_oe[15:8]});
    acc(1, IDX_BUS_CONFIG_ZERO, 8'h00, r);
    d = 16'($random(seed));
    acc(1, IDX_BUS_PORT_LOW_DATA, d[15:8], r);
    acc(1, IDX_BUS_PORT_LOW_DIR, d[7:0], r);
    chk("bus_port_oe", {v, d[7:0]}, bus_port_oe);
    chk("bus_port_out", {8'h00, d[15:8]}, {8'h00, bus_port_out[7:0]});
    chk("ready_off", 16'h0000, {15'h0000, ext_ready});
    // second port halves written at random
    for (m = 0; m < 12; m++) begin
      k = $random(seed) & 3;
      v = 8'($random(seed));
      acc(1, idx2[k], v, r);
      sp[k] = v;
      chk("second_out", {sp[1], sp[0]}, second_port_out);
      chk("second_oe", {sp[3], sp[2]}, second_port_oe);
      acc(0, idx2[k], 8'h00, r);
      chk("second_read", {8'h00, v}, {8'h00, r});
    end
    acc(0, 16'h0000, 8'h00, r);
    chk("unmapped", 16'h0000, {8'h00, r});
    acc(1, IDX_STARTUP_READBACK, 8'h00, r);
    acc(0, IDX_STARTUP_READBACK, 8'h00, r);
    chk("readback_ro", 16'h00A5, {8'h00, r});
    // a write without byte lane 0 is dropped
    be = 4'hE;
    acc(1, idx2[0], ~sp[0], r);
    be = 4'hF;
    acc(0, idx2[0], 8'h00, r);
    chk("lane_dropped", {8'h00, sp[0]}, {8'h00, r});
    // second reset with different straps: bus comes up disabled
    rst <= 1'b1;
    strap <= 16'h3CFB;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    boot_check(8'h3C, 8'hFB);
    chk("ready_strap", 16'h0000, {15'h0000, ext_ready});
    chk("second_out_rst", 16'h0000, second_port_out);
    report_and_stop;
  end
endmodule

// file: tb/ext_mem_model.sv
// far-side model: external memory and strap pull-downs on the bus port
`timescale 1ns/10ps
module ext_mem_model (
  input  wire logic        clk,
  input  wire logic        byte_mode,
  input  wire logic [15:0] strap,
  input  wire logic [15:0] rd_word,
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  input  wire logic [15:0] pin_pullup,
  input  wire logic        rd_strobe,
  output logic      [15:0] pin_in
);
  logic        hi_q   = 1'b0;
  logic [15:0] last_q = 16'h0000;
  logic [15:0] mem_d;
  logic [15:0] mem_en;
  // 8-bit bus answers low byte first, then high byte
  always_comb begin
    mem_d  = byte_mode ? {8'h00, hi_q ? rd_word[15:8] : rd_word[7:0]} : rd_word;
    mem_en = rd_strobe ? (byte_mode ? 16'h00FF : 16'hFFFF) : 16'h0000;
  end
  // pull-downs beat pull-ups; floating lines wander so stale values never pass
  always_comb begin
    for (int b = 0; b < 16; b++) begin
      if (pin_oe[b]) pin_in[b] = pin_out[b];
      else if (mem_en[b]) pin_in[b] = mem_d[b];
      else if (pin_pullup[b]) pin_in[b] = strap[b];
      else pin_in[b] = strap[b] & ~last_q[b];
    end
  end
  always_ff @(posedge clk) begin
    last_q <= pin_in;
    hi_q   <= byte_mode && (rd_strobe ? !hi_q : hi_q);
  end
endmodule

// file: verilog/bus_port_pair.sv
// bus port pair: external bus port with start-up straps and a second port
// Function
// [R01] bus port carries data or address/data
// [R02] 8-bit demux uses low half only
// [R03] reset: bus port inputs with pull-ups
// [R04] high pin keeps default, low changes it
// [R05] sampled configuration loads bus config zero
// [R06] sampled high byte into read-only readback
// [R07] reset end drops pull-ups, enters mode
// [R08] mux access: address first, then input
// [R09] 8-bit bus: word as two byte cycles
// [R10] mux write drives data after address
// [R11] demux modes carry data only
// [R12] bus controller owns direction and latch
// [R13] read data returns on dedicated path
// [R14] software avoids latch writes during bus
// [R15] bus off: last written direction active
// [R16] second port halves written independently
// [R17] second port data halves reset zero
// [R18] direction zero input, one drives
// [R19] second port directions reset to zero
// [R20] bus port direction bit per line
// [R21] capture straps at reset release, hold
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/10ps

module bus_port_pair
  import bus_port_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  // avalon-mm register slave
  input  wire logic [AVS_ADDR_W-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [3:0]            avs_byteenable,
  input  wire logic [31:0]           avs_writedata,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  // bus controller access port
  input  wire logic                  ext_valid,
  input  wire ext_req_t              ext_req,
  output logic                       ext_ready,
  output logic                       ext_ack,
  output logic      [15:0]           ext_rdata,
  // external bus strobes
  output logic                       bus_addr_latch,
  output logic                       bus_read_strobe,
  output logic                       bus_write_strobe,
  // bus port pins
  input  wire logic [15:0]           bus_port_in,
  output logic      [15:0]           bus_port_out,
  output logic      [15:0]           bus_port_oe,
  output logic      [15:0]           bus_port_pullup,
  // second port pins
  input  wire logic [15:0]           second_port_in,
  output logic      [15:0]           second_port_out,
  output logic      [15:0]           second_port_oe
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // software-visible registers and sequencer state
  logic [7:0]   bus_port_low_half_q;
  logic [7:0]   bus_port_high_half_q;
  logic [7:0]   bus_port_low_direction_q;
  logic [7:0]   bus_port_high_direction_q;
  logic [7:0]   second_port_low_data_q;
  logic [7:0]   second_port_high_data_q;
  logic [7:0]   second_port_low_direction_q;
  logic [7:0]   second_port_high_direction_q;
  logic [7:0]   bus_config_reg_zero_q;
  logic [7:0]   startup_config_readback_q;
  logic         in_reset_q;
  logic         ack_q;
  logic [31:0]  readdata_q;
  ext_state_t   state_q;
  ext_req_t     req_q;
  logic         byte_sel_q;
  logic [15:0]  rdata_q;

  // decode and drive helpers
  logic [15:0]  idx;
  logic         wr_take;
  logic         bus_on;
  logic [1:0]   mode;
  logic         is_mux;
  logic         is_8bit;
  logic         high_claimed;
  logic         second_byte;
  logic [7:0]   wbyte;
  pin_drive_t   bus_drv;
  pin_drive_t   gpio_drv;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign idx          = avs_address[17:2];
  assign wr_take      = avs_write & ack_q;
  assign wbyte        = avs_writedata[7:0];
  assign bus_on       = bus_config_reg_zero_q[CFG_ENABLE] & ~in_reset_q;
  assign mode         = bus_config_reg_zero_q[CFG_MODE_MSB:CFG_MODE_LSB];
  assign is_mux       = (mode == MODE_MUX8) | (mode == MODE_MUX16);
  assign is_8bit      = (mode == MODE_MUX8) | (mode == MODE_DEMUX8);
  // with the bus on, high half stays general purpose only in 8-bit demux mode
  assign high_claimed = bus_on & (mode != MODE_DEMUX8); // [R02]
  // a word on an 8-bit bus needs one more byte cycle
  assign second_byte  = is_8bit & req_q.word & ~byte_sel_q; // [R09]

  // ----------------------------------------------------------------
  // reset tracking and strap capture
  // ----------------------------------------------------------------
  // in_reset_q stays high for the edge after release, so the pull-ups
  // are still on while the straps are sampled
  always_ff @(posedge clk) begin
    if (rst) begin
      in_reset_q <= 1'b1;
    end else begin
      in_reset_q <= 1'b0; // [R07]
    end
  end

  // readback holds the high-byte straps; nothing else ever writes it
  always_ff @(posedge clk) begin
    if (rst) begin
      startup_config_readback_q <= CONFIG_RESET;
    end else if (in_reset_q) begin
      startup_config_readback_q <= bus_port_in[15:8]; // [R06] [R21]
    end
  end

  // ----------------------------------------------------------------
  // avalon-mm slave: one wait cycle per access
  // ----------------------------------------------------------------
  // waitrequest drops on the second cycle of every request
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata    = readdata_q;

  // read mux, loaded in the wait cycle; unmapped reads return zero
  // readdata then holds until the next read loads it
  always_ff @(posedge clk) begin
    if (rst) begin
      readdata_q <= 32'h0000_0000;
    end else if (avs_read & ~ack_q) begin
      readdata_q <= 32'h0000_0000;
      unique case (idx)
        IDX_BUS_PORT_LOW_DATA:  readdata_q[7:0] <= bus_port_low_half_q;
        IDX_BUS_PORT_HIGH_DATA: readdata_q[7:0] <= bus_port_high_half_q;
        IDX_SECOND_LOW_DATA:    readdata_q[7:0] <= second_port_low_data_q;
        IDX_SECOND_HIGH_DATA:   readdata_q[7:0] <= second_port_high_data_q;
        IDX_BUS_PORT_LOW_DIR:   readdata_q[7:0] <= bus_port_low_direction_q;
        IDX_BUS_PORT_HIGH_DIR:  readdata_q[7:0] <= bus_port_high_direction_q;
        IDX_SECOND_LOW_DIR:     readdata_q[7:0] <= second_port_low_direction_q;
        IDX_SECOND_HIGH_DIR:    readdata_q[7:0] <= second_port_high_direction_q;
        IDX_BUS_CONFIG_ZERO:    readdata_q[7:0] <= bus_config_reg_zero_q;
        IDX_STARTUP_READBACK:   readdata_q[7:0] <= startup_config_readback_q;
        default:                readdata_q      <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bus port registers
  // ----------------------------------------------------------------
  // latch writes while the bus is on are stored; only the high half reaches
  // the pins, in 8-bit demux mode; software is expected not to make them
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_port_low_half_q  <= HALF_RESET;
      bus_port_high_half_q <= HALF_RESET;
    end else if (wr_take & avs_byteenable[0]) begin
      if (idx == IDX_BUS_PORT_LOW_DATA) begin
        bus_port_low_half_q <= wbyte; // [R14]
      end
      if (idx == IDX_BUS_PORT_HIGH_DATA) begin
        bus_port_high_half_q <= wbyte;
      end
    end
  end

  // directions are kept through bus mode so they come back unchanged
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_port_low_direction_q  <= HALF_RESET;
      bus_port_high_direction_q <= HALF_RESET;
    end else if (wr_take & avs_byteenable[0]) begin
      if (idx == IDX_BUS_PORT_LOW_DIR) begin
        bus_port_low_direction_q <= wbyte; // [R20] [R15]
      end
      if (idx == IDX_BUS_PORT_HIGH_DIR) begin
        bus_port_high_direction_q <= wbyte; // [R20] [R15]
      end
    end
  end

  // straps land in bus config zero at release; software may rewrite it
  // the mode field is live, so rewrite it only between accesses
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_config_reg_zero_q <= CONFIG_RESET;
    end else if (in_reset_q) begin
      bus_config_reg_zero_q <= bus_port_in[7:0]; // [R05] [R04] [R21]
    end else if (wr_take & avs_byteenable[0] & (idx == IDX_BUS_CONFIG_ZERO)) begin
      bus_config_reg_zero_q <= wbyte;
    end
  end

  // ----------------------------------------------------------------
  // second port registers
  // ----------------------------------------------------------------
  // each half is its own register, so a byte write never touches the
  // other half, whichever master makes it
  always_ff @(posedge clk) begin
    if (rst) begin
      second_port_low_data_q  <= HALF_RESET; // [R17]
      second_port_high_data_q <= HALF_RESET; // [R17]
    end else if (wr_take & avs_byteenable[0]) begin
      if (idx == IDX_SECOND_LOW_DATA) begin
        second_port_low_data_q <= wbyte; // [R16]
      end
      if (idx == IDX_SECOND_HIGH_DATA) begin
        second_port_high_data_q <= wbyte; // [R16]
      end
    end
  end

  // every second port line leaves reset as an input
  always_ff @(posedge clk) begin
    if (rst) begin
      second_port_low_direction_q  <= HALF_RESET; // [R19]
      second_port_high_direction_q <= HALF_RESET; // [R19]
    end else if (wr_take & avs_byteenable[0]) begin
      if (idx == IDX_SECOND_LOW_DIR) begin
        second_port_low_direction_q <= wbyte; // [R16]
      end
      if (idx == IDX_SECOND_HIGH_DIR) begin
        second_port_high_direction_q <= wbyte; // [R16]
      end
    end
  end

  // second port pins; input path is unused here, capture is elsewhere
  assign second_port_out = {second_port_high_data_q, second_port_low_data_q};
  assign second_port_oe  = {second_port_high_direction_q,
                            second_port_low_direction_q}; // [R18]

  // ----------------------------------------------------------------
  // external access sequencer
  // ----------------------------------------------------------------
  // a request is taken only in idle with the bus on
  assign ext_ready = (state_q == ST_IDLE) & bus_on;
  assign ext_ack   = (state_q == ST_DONE);
  assign ext_rdata = rdata_q;

  // sequencer state; demux modes skip the address phase on this port
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (ext_valid & ext_ready) begin
            state_q <= is_mux ? ST_ADDR : ST_DATA; // [R01] [R08] [R11]
          end
        end
        ST_ADDR: begin
          state_q <= ST_DATA; // [R10]
        end
        ST_DATA: begin
          if (second_byte) begin
            state_q <= is_mux ? ST_ADDR : ST_DATA; // [R09]
          end else begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // the request is held for the whole access; the bus controller may
  // change its own copy as soon as the access is taken
  always_ff @(posedge clk) begin
    if (rst) begin
      req_q <= '0;
    end else if (ext_valid & ext_ready) begin
      req_q <= ext_req;
    end
  end

  // byte select starts low for every access, low byte first
  always_ff @(posedge clk) begin
    if (rst) begin
      byte_sel_q <= 1'b0;
    end else if (state_q == ST_IDLE) begin
      byte_sel_q <= 1'b0;
    end else if ((state_q == ST_DATA) & second_byte) begin
      byte_sel_q <= 1'b1; // [R09]
    end
  end

  // read data is taken at the end of each data phase
  // a first byte clears the upper half so no stale byte survives
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else if ((state_q == ST_DATA) & ~req_q.write) begin
      if (!is_8bit) begin
        rdata_q <= bus_port_in; // [R13]
      end else if (byte_sel_q) begin
        rdata_q[15:8] <= bus_port_in[7:0]; // [R09] [R13]
      end else begin
        rdata_q <= {8'h00, bus_port_in[7:0]}; // [R09] [R13]
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  assign bus_addr_latch   = (state_q == ST_ADDR);
  assign bus_read_strobe  = (state_q == ST_DATA) & ~req_q.write;
  assign bus_write_strobe = (state_q == ST_DATA) & req_q.write;

  // bus controller drive: address, then data or release for input
  // lines are released outside phases so strap pull-downs never fight
  always_comb begin
    bus_drv = '0;
    if (state_q == ST_ADDR) begin
      bus_drv.out = {req_q.addr[15:1], req_q.addr[0] | byte_sel_q}; // [R08]
      bus_drv.oe  = 16'hFFFF; // [R08]
    end else if ((state_q == ST_DATA) & req_q.write) begin
      if (is_8bit) begin
        bus_drv.out = {8'h00, byte_sel_q ? req_q.wdata[15:8] : req_q.wdata[7:0]};
        bus_drv.oe  = 16'h00FF; // [R10] [R11]
      end else begin
        bus_drv.out = req_q.wdata; // [R10] [R11]
        bus_drv.oe  = 16'hFFFF;
      end
    end
  end

  // general purpose drive from the latches and directions
  assign gpio_drv.out = {bus_port_high_half_q, bus_port_low_half_q};
  assign gpio_drv.oe  = {bus_port_high_direction_q,
                         bus_port_low_direction_q}; // [R20] [R15]

  // per half ownership; reset forces inputs with pull-ups
  always_comb begin
    bus_port_out    = gpio_drv.out;
    bus_port_oe     = gpio_drv.oe;
    bus_port_pullup = in_reset_q ? 16'hFFFF : 16'h0000; // [R03] [R07]
    if (in_reset_q) begin
      bus_port_oe = 16'h0000; // [R03]
    end else if (bus_on) begin
      bus_port_out[7:0] = bus_drv.out[7:0]; // [R12]
      bus_port_oe[7:0]  = bus_drv.oe[7:0]; // [R12]
      if (high_claimed) begin
        bus_port_out[15:8] = bus_drv.out[15:8]; // [R12] [R02]
        bus_port_oe[15:8]  = bus_drv.oe[15:8]; // [R12]
      end
    end
  end

endmodule

// file: verilog/bus_port_pkg.sv
// constants, register map and carrier types for the bus port pair
package bus_port_pkg;

  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_BUS_PORT_LOW_DATA   = 16'hFF00;
  localparam logic [15:0] IDX_BUS_PORT_HIGH_DATA  = 16'hFF02;
  localparam logic [15:0] IDX_SECOND_LOW_DATA     = 16'hFF04;
  localparam logic [15:0] IDX_SECOND_HIGH_DATA    = 16'hFF06;
  localparam logic [15:0] IDX_BUS_PORT_LOW_DIR    = 16'hF100;
  localparam logic [15:0] IDX_BUS_PORT_HIGH_DIR   = 16'hF102;
  localparam logic [15:0] IDX_SECOND_LOW_DIR      = 16'hF104;
  localparam logic [15:0] IDX_SECOND_HIGH_DIR     = 16'hF106;
  localparam logic [15:0] IDX_BUS_CONFIG_ZERO     = 16'hFF0C;
  localparam logic [15:0] IDX_STARTUP_READBACK    = 16'hF108;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int          HALF_W        = 8;
  localparam int          PORT_W        = 16;
  localparam int          AVS_ADDR_W    = 18;
  localparam logic [7:0]  HALF_RESET    = 8'h00;
  localparam logic [7:0]  CONFIG_RESET  = 8'h00;

  // ----------------------------------------------------------------
  // bus configuration field layout
  // ----------------------------------------------------------------
  localparam int          CFG_MODE_LSB  = 0;
  localparam int          CFG_MODE_MSB  = 1;
  localparam int          CFG_ENABLE    = 2;

  // bus modes held in the mode field
  localparam logic [1:0]  MODE_DEMUX8   = 2'h0;
  localparam logic [1:0]  MODE_MUX8     = 2'h1;
  localparam logic [1:0]  MODE_DEMUX16  = 2'h2;
  localparam logic [1:0]  MODE_MUX16    = 2'h3;

  // external access sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_DATA = 4'b0100,
    ST_DONE = 4'b1000
  } ext_state_t;

  // one external access request from the bus controller
  typedef struct packed {
    logic        write;
    logic        word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ext_req_t;

  // a group of pin controls for one 16-bit port
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
  } pin_drive_t;

endpackage
